// ===== msc_top.sv
// Purpose: mission status flags, start delay, timestamp and sample counters
// Assumes: apb master, measurement and tick inputs all on mclk_i
// Notes: commands arrive as pulses written to the command register
//
// Overview of operation
// - general status read-only; bits 7,6 read one, bits 5,2,0 read zero
// - battery loss flag set by power-on reset, never masked
// - humidity high flag set and held when reading at or above threshold
// - humidity low flag set and held when reading at or below threshold
// - temperature high flag set at or above threshold, also by trigger
// - temperature low flag set at or below threshold, also by trigger
// - forced conversion updates the four flags with same comparisons
// - a threshold flag is set only when its enable bit is set
// - awaiting alarm set on alarm-start mission, cleared by first alarm
// - awaiting alarm untouched by clear memory and by mission stop
// - clear memory zeroes timestamp, mission count, flags; sets cleared
// - start needs memory cleared; start drops the cleared bit
// - mission active held from start until mission ends
// - start delay is 24-bit minutes, low byte first, locked in mission
// - wait the delay before first sample or before alarm testing
// - capture rtc date and time of first sample as six bcd bytes
// - mission count is read-only 24-bit wake-up count, zeroed by clear
// - both readings in one wake-up count once
// - triggering sample in alarm-start mode is not counted in mission
// - read-only 24-bit device sample count, low byte first
// - alarm-start mode tests temperature each sample, logs after alarm
// - device count bumps on wake-ups, alarm tests, idle forced runs
`timescale 1ns/1ps
module msc_top (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [msc_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [msc_pkg::DATA_W-1:0] pwdata_i,
   output logic [msc_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // time base
   input wire logic minute_tick_i,
   input wire logic sample_tick_i,
   input wire logic [msc_pkg::STAMP_W-1:0] rtc_time_i,
   // measurement results
   input wire msc_pkg::msc_meas_type meas_i,
   input wire msc_pkg::msc_thresh_type thresh_i,
   // status out
   output logic sample_req_o,
   output logic mission_active_o
);
   import msc_pkg::*;

   // returns {at_or_above_hi, at_or_below_lo}
   function automatic logic [1:0] cmp_fn(input logic [7:0] v,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
      cmp_fn = {v >= hi, v <= lo};
   endfunction : cmp_fn

   function automatic logic [7:0] byte_fn(input logic [STAMP_W-1:0] v,
                                          input logic [9:0] k);
      byte_fn = v[k[2:0]*8 +: 8];
   endfunction : byte_fn

   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rst_n;
   logic pready_ff;
   logic pslverr_ff;
   logic [DATA_W-1:0] prdata_ff;
   logic [7:0] alarm_ff;
   logic [7:0] ctrl_ff;
   logic awaiting_alarm_ff;
   logic memory_cleared_ff;
   logic mission_active_ff;
   logic first_pending_ff;
   logic sample_req_ff;
   msc_state_type state_ff;
   logic [CNT_W-1:0] delay_ff;
   logic [CNT_W-1:0] work_cnt_ff;
   logic [CNT_W-1:0] mission_cnt_ff;
   logic [CNT_W-1:0] device_cnt_ff;
   logic [STAMP_W-1:0] stamp_ff;
   logic [9:0] idx;
   logic apb_access;
   logic wr_done;
   logic cmd_wr;
   logic do_clear;
   logic do_start;
   logic do_stop;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic [1:0] t_hit;
   logic [1:0] h_hit;
   logic in_test;
   logic meas_mis;
   logic meas_forced;
   logic use_temp;
   logic use_humid;
   logic trigger;
   logic meas_log;
   logic temp_event;
   logic [7:0] set_mask;

   // reset release through two flops
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   // apb decode: one wait state, write lands on the edge pready is seen
   assign idx = paddr_i[ADDR_W-1:2];
   assign apb_access = psel_i & penable_i & ~pready_ff;
   assign wr_done = psel_i & penable_i & pready_ff & pwrite_i;
   assign cmd_wr = wr_done & (idx == IDX_CMD);
   assign do_clear = cmd_wr & pwdata_i[CMD_CLEAR] & ~pwdata_i[CMD_START]
                     & ~mission_active_ff;
   assign do_start = cmd_wr & pwdata_i[CMD_START] & memory_cleared_ff
                     & ~mission_active_ff
                     & (ctrl_ff[CTL_TLOG] | ctrl_ff[CTL_HLOG]);
   assign do_stop = cmd_wr & pwdata_i[CMD_STOP] & mission_active_ff;

   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      if (idx == IDX_ALARM) begin
         rd_byte = alarm_ff | ALARM_FIXED;
      end else if (idx == IDX_GSTAT) begin
         rd_byte = GSTAT_FIXED;
         rd_byte[BIT_AWAIT] = awaiting_alarm_ff;
         rd_byte[BIT_MEMORY_CLEARED] = memory_cleared_ff;
         rd_byte[BIT_ACTIVE] = mission_active_ff;
      end else if (idx >= IDX_DELAY && idx < IDX_DELAY + CNT_BYTES) begin
         rd_byte = byte_fn({24'h00_0000, delay_ff}, idx - IDX_DELAY);
      end else if (idx >= IDX_STAMP && idx < IDX_STAMP + STAMP_BYTES) begin
         rd_byte = byte_fn(stamp_ff, idx - IDX_STAMP);
      end else if (idx >= IDX_MCNT && idx < IDX_MCNT + CNT_BYTES) begin
         rd_byte = byte_fn({24'h00_0000, mission_cnt_ff}, idx - IDX_MCNT);
      end else if (idx >= IDX_DCNT && idx < IDX_DCNT + CNT_BYTES) begin
         rd_byte = byte_fn({24'h00_0000, device_cnt_ff}, idx - IDX_DCNT);
      end else if (idx == IDX_CTRL) begin
         rd_byte = ctrl_ff;
      end else if (idx == IDX_CMD) begin
         rd_byte = 8'h00;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= apb_access;
         pslverr_ff <= apb_access & ~rd_hit;
         if (apb_access) begin
            prdata_ff <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         end
      end
   end

   // control bits lock while a mission runs
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_done & (idx == IDX_CTRL) & ~mission_active_ff) begin
         ctrl_ff <= pwdata_i[7:0];
      end
   end

   // start delay register
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         delay_ff <= 24'h00_0000;
      end else if (wr_done & ~mission_active_ff) begin
         if (idx == IDX_DELAY) begin
            delay_ff[7:0] <= pwdata_i[7:0];
         end else if (idx == IDX_DELAY + 10'h1) begin
            delay_ff[15:8] <= pwdata_i[7:0];
         end else if (idx == IDX_DELAY + 10'h2) begin
            delay_ff[23:16] <= pwdata_i[7:0];
         end
      end
   end

   // measurement classification
   assign t_hit = cmp_fn(meas_i.temp, thresh_i.temp_hi, thresh_i.temp_lo);
   assign h_hit = cmp_fn(meas_i.humid, thresh_i.humid_hi,
                         thresh_i.humid_lo);
   assign in_test = (state_ff == ST_WAIT_ALARM) | (state_ff == ST_LOGGING);
   assign meas_mis = meas_i.valid & ~meas_i.forced & in_test;
   assign meas_forced = meas_i.valid & meas_i.forced & ~mission_active_ff;
   assign use_temp = (meas_mis | meas_forced) & meas_i.has_temp;
   // humidity is not sampled while only waiting for a temperature alarm
   assign use_humid = meas_i.has_humid
                      & (meas_forced | (meas_mis & state_ff == ST_LOGGING));
   assign trigger = meas_mis & (state_ff == ST_WAIT_ALARM)
                    & meas_i.has_temp & (|t_hit);
   assign meas_log = meas_mis & (state_ff == ST_LOGGING);
   assign temp_event = use_temp & (|t_hit);

   always_comb begin
      set_mask = 8'h00;
      set_mask[BIT_HH] = use_humid & h_hit[1] & ctrl_ff[CTL_HH_EN];
      set_mask[BIT_HL] = use_humid & h_hit[0] & ctrl_ff[CTL_HL_EN];
      set_mask[BIT_TH] = use_temp & t_hit[1] & ctrl_ff[CTL_TH_EN];
      set_mask[BIT_TL] = use_temp & t_hit[0] & ctrl_ff[CTL_TL_EN];
   end

   // sticky alarm flags, a new set beats a clear in the same cycle
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         alarm_ff <= ALARM_RST;
      end else if (do_clear) begin
         alarm_ff <= set_mask;
      end else begin
         alarm_ff <= alarm_ff | set_mask;
      end
   end

   // waiting for temperature alarm
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         awaiting_alarm_ff <= 1'b0;
      end else if (do_start) begin
         awaiting_alarm_ff <= ctrl_ff[CTL_ASTART];
      end else if (temp_event) begin
         // forced run with a low threshold also clears it
         awaiting_alarm_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         memory_cleared_ff <= 1'b0;
      end else if (do_clear) begin
         memory_cleared_ff <= 1'b1;
      end else if (do_start) begin
         memory_cleared_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         mission_active_ff <= 1'b0;
      end else if (do_start) begin
         mission_active_ff <= 1'b1;
      end else if (do_stop) begin
         mission_active_ff <= 1'b0;
      end
   end

   // mission sequencing
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
      end else if (do_stop) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (do_start) begin
                  state_ff <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (work_cnt_ff == 24'h00_0000) begin
                  state_ff <= ctrl_ff[CTL_ASTART] ? ST_WAIT_ALARM
                                                  : ST_LOGGING;
               end
            end
            ST_WAIT_ALARM: begin
               if (trigger) begin
                  state_ff <= ST_LOGGING;
               end
            end
            ST_LOGGING: begin
               state_ff <= ST_LOGGING;
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // delay counter runs on the minute tick, separate from the register
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         work_cnt_ff <= 24'h00_0000;
      end else if (do_start) begin
         work_cnt_ff <= delay_ff;
      end else if (state_ff == ST_DELAY && minute_tick_i &&
                   work_cnt_ff != 24'h00_0000) begin
         work_cnt_ff <= work_cnt_ff - 24'h00_0001;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         sample_req_ff <= 1'b0;
      end else begin
         sample_req_ff <= sample_tick_i & in_test & ~do_stop;
      end
   end

   // timestamp of the first logged sample
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         first_pending_ff <= 1'b0;
      end else if (do_start) begin
         first_pending_ff <= 1'b1;
      end else if (meas_log | trigger) begin
         first_pending_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         stamp_ff <= 48'h0000_0000_0000;
      end else if (do_clear) begin
         stamp_ff <= 48'h0000_0000_0000;
      end else if (first_pending_ff & (meas_log | trigger)) begin
         stamp_ff <= rtc_time_i;
      end
   end

   // counters: one count per wake-up, readings arrive together
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         mission_cnt_ff <= 24'h00_0000;
      end else if (do_clear) begin
         mission_cnt_ff <= 24'h00_0000;
      end else if (meas_log) begin
         // trigger sample is logged but not counted
         mission_cnt_ff <= mission_cnt_ff + 24'h00_0001;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         device_cnt_ff <= 24'h00_0000;
      end else if (meas_mis | meas_forced) begin
         device_cnt_ff <= device_cnt_ff + 24'h00_0001;
      end
   end

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign sample_req_o = sample_req_ff;
   assign mission_active_o = mission_active_ff;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   chk_gstat_fixed: assert property (
      (apb_access && !pwrite_i && idx == IDX_GSTAT) |=>
         (prdata_o[7:5] == 3'b110 && prdata_o[2] == 1'b0 &&
          prdata_o[0] == 1'b0 && pready_o))
      else $error("general status fixed bits wrong");
   chk_batt_no_rise: assert property (
      !alarm_ff[BIT_BATT] |=> !alarm_ff[BIT_BATT])
      else $error("battery flag set outside reset");
   chk_hh_set: assert property (
      (use_humid && h_hit[1] && ctrl_ff[CTL_HH_EN]) |=> alarm_ff[BIT_HH])
      else $error("humidity high flag not set");
   chk_tl_hold: assert property (
      (alarm_ff[BIT_TL] && !do_clear) |=> alarm_ff[BIT_TL])
      else $error("temperature low flag dropped");
   chk_th_gated: assert property (
      (!ctrl_ff[CTL_TH_EN] && !alarm_ff[BIT_TH]) |=> !alarm_ff[BIT_TH])
      else $error("disabled temperature high flag set");
   chk_await_start: assert property (
      (do_start && ctrl_ff[CTL_ASTART]) |=>
         (awaiting_alarm_ff && mission_active_ff && !memory_cleared_ff))
      else $error("alarm start not flagged");
   chk_await_clear_mem: assert property (
      (awaiting_alarm_ff && do_clear && !temp_event) |=> awaiting_alarm_ff)
      else $error("clear memory touched awaiting alarm");
   chk_clear_effect: assert property (
      do_clear |=> (memory_cleared_ff && mission_cnt_ff == 24'h00_0000 &&
                    stamp_ff == 48'h0000_0000_0000))
      else $error("clear memory incomplete");
   chk_start_refused: assert property (
      (cmd_wr && pwdata_i[CMD_START] && !memory_cleared_ff &&
       !mission_active_ff) |=> !mission_active_ff)
      else $error("start without cleared memory");
   chk_active_hold: assert property (
      (mission_active_ff && !do_stop) |=> mission_active_ff)
      else $error("mission active dropped");
   chk_delay_locked: assert property (
      mission_active_ff |=> $stable(delay_ff))
      else $error("start delay changed in mission");
   chk_delay_wait: assert property (
      (state_ff == ST_DELAY && work_cnt_ff != 24'h00_0000) |=>
         !sample_req_o)
      else $error("sample before delay expired");
   chk_once_per_wake: assert property (
      (meas_log && !do_clear) |=>
         mission_cnt_ff == $past(mission_cnt_ff) + 24'h00_0001)
      else $error("mission count step wrong");
   chk_trigger_count: assert property (
      (trigger && !do_stop) |=>
         ($stable(mission_cnt_ff) && state_ff == ST_LOGGING &&
         device_cnt_ff == $past(device_cnt_ff) + 24'h00_0001))
      else $error("trigger sample counted wrongly");
endmodule : msc_top

// ===== msc_pkg.sv
// Purpose: constants and types for the mission status and counter bank
// Assumes: register indices are word indices; byte address is index * 4
// Notes: one byte of register data per 32-bit apb word
package msc_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int CNT_W = 24;
   localparam int STAMP_W = 48;
   // register indices
   localparam logic [9:0] IDX_ALARM = 10'h214;
   localparam logic [9:0] IDX_GSTAT = 10'h215;
   localparam logic [9:0] IDX_DELAY = 10'h216;
   localparam logic [9:0] IDX_STAMP = 10'h219;
   localparam logic [9:0] IDX_MCNT = 10'h220;
   localparam logic [9:0] IDX_DCNT = 10'h223;
   localparam logic [9:0] IDX_CTRL = 10'h240;
   localparam logic [9:0] IDX_CMD = 10'h241;
   localparam logic [9:0] CNT_BYTES = 10'h3;
   localparam logic [9:0] STAMP_BYTES = 10'h6;
   // alarm status layout
   localparam int BIT_BATT = 7;
   localparam int BIT_HH = 3;
   localparam int BIT_HL = 2;
   localparam int BIT_TH = 1;
   localparam int BIT_TL = 0;
   localparam logic [7:0] ALARM_FIXED = 8'h70;
   localparam logic [7:0] ALARM_RST = 8'h80;
   // general status layout
   localparam int BIT_AWAIT = 4;
   localparam int BIT_MEMORY_CLEARED = 3;
   localparam int BIT_ACTIVE = 1;
   localparam logic [7:0] GSTAT_FIXED = 8'hc0;
   // control register layout
   localparam int CTL_TL_EN = 0;
   localparam int CTL_TH_EN = 1;
   localparam int CTL_HL_EN = 2;
   localparam int CTL_HH_EN = 3;
   localparam int CTL_TLOG = 4;
   localparam int CTL_HLOG = 5;
   localparam int CTL_ASTART = 6;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // command register layout
   localparam int CMD_CLEAR = 0;
   localparam int CMD_START = 1;
   localparam int CMD_STOP = 2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_DELAY = 4'b0010,
      ST_WAIT_ALARM = 4'b0100,
      ST_LOGGING = 4'b1000
   } msc_state_type;

   typedef struct packed {
      logic valid;
      logic forced;
      logic has_temp;
      logic has_humid;
      logic [7:0] temp;
      logic [7:0] humid;
   } msc_meas_type;

   typedef struct packed {
      logic [7:0] temp_hi;
      logic [7:0] temp_lo;
      logic [7:0] humid_hi;
      logic [7:0] humid_lo;
   } msc_thresh_type;
endpackage : msc_pkg

// ===== msc_host.sv
// Purpose: host master model on the register bus
// Assumes: one byte of register data per word, all on the rising edge
// Notes: a wait without pready is cut at 64 cycles and flagged as hung
`timescale 1ns/1ps
module msc_host (
   // clock
   input wire logic mclk_i,
   // apb master
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [msc_pkg::ADDR_W-1:0] paddr_o,
   output logic [msc_pkg::DATA_W-1:0] pwdata_o,
   input wire logic [msc_pkg::DATA_W-1:0] prdata_i,
   input wire logic pready_i,
   input wire logic pslverr_i
);
   import msc_pkg::*;
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = '0;
      pwdata_o = '0;
   end
   // request held unchanged until pready is seen at a rising edge
   task automatic xfer(input logic wr, input logic [9:0] idx,
      input logic [7:0] wd, output logic [7:0] rd, output logic err,
      output logic hung);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= wr;
      paddr_o <= {idx, 2'b00};
      pwdata_o <= {24'h00_0000, wd};
      @(posedge mclk_i);
      penable_o <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_i !== 1'b1 && n < 64);
      rd = prdata_i[7:0];
      err = pslverr_i;
      hung = (pready_i !== 1'b1);
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask : xfer
endmodule : msc_host

// ===== mission_status_counters_test.sv
// Purpose: self-checking bench for the status and counter bank
// Assumes: thresholds c0 high and 40 low; one forced run lowers the high
// Notes: device count is checked as a delta, its reset value is free
`timescale 1ns/1ps
module mission_status_counters_test;
   import msc_pkg::*;
   logic mclk_i;
   logic rst_n_i;
   logic psel;
   logic penable;
   logic pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic minute_tick;
   logic sample_tick;
   logic [STAMP_W-1:0] rtc;
   msc_meas_type meas;
   msc_thresh_type thresh;
   logic sample_req;
   logic active;
   int fail_count = 0;
   int samples_checked = 0;
   int seed = 32'h3845;
   logic [47:0] d0;
   logic [47:0] stamp;
   logic [7:0] f;
   logic [7:0] t;
   logic [7:0] h;
   logic e;
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   msc_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .minute_tick_i(minute_tick),
      .sample_tick_i(sample_tick), .rtc_time_i(rtc), .meas_i(meas),
      .thresh_i(thresh), .sample_req_o(sample_req),
      .mission_active_o(active));
   msc_host u_host (.mclk_i(mclk_i), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
      .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [47:0] got,
      input logic [47:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [9:0] idx,
      input logic [7:0] wd, output logic [7:0] rd, output logic err);
      logic hung;
      u_host.xfer(wr, idx, wd, rd, err, hung);
      if (hung) begin
         fail_count++;
         print_verdict();
      end
   endtask : bus
   task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
      logic [7:0] rd;
      logic err;
      bus(1'b1, idx, wd, rd, err);
   endtask : wr
   // multi-byte values sit low byte first at rising indices
   task automatic rd_reg(input logic [9:0] idx, input int n,
      output logic [47:0] val);
      logic [7:0] rd;
      logic err;
      val = '0;
      for (int k = 0; k < n; k++) begin
         bus(1'b0, idx + 10'(k), 8'h00, rd, err);
         val[8*k +: 8] = rd;
      end
   endtask : rd_reg
   task automatic expect_reg(input string nm, input logic [9:0] idx,
      input int n, input logic [47:0] exp);
      logic [47:0] val;
      rd_reg(idx, n, val);
      chk(nm, val, exp);
   endtask : expect_reg
   task automatic pulse_meas(input logic frc, input logic [7:0] tt,
      input logic [7:0] hh);
      @(posedge mclk_i);
      meas <= '{1'b1, frc, 1'b1, 1'b1, tt, hh};
      @(posedge mclk_i);
      meas.valid <= 1'b0;
   endtask : pulse_meas
   task automatic minutes2();
      repeat (2) begin
         @(posedge mclk_i);
         minute_tick <= 1'b1;
         @(posedge mclk_i);
         minute_tick <= 1'b0;
      end
      repeat (3) @(posedge mclk_i);
   endtask : minutes2
   task automatic sreq_chk(input logic exp);
      @(posedge mclk_i);
      sample_tick <= 1'b1;
      @(posedge mclk_i);
      sample_tick <= 1'b0;
      #1;
      chk("sreq", sample_req, exp);
   endtask : sreq_chk
   // flags stick; humidity low alarm left disabled on purpose
   function automatic logic [7:0] exp_flags(logic [7:0] fl,
      logic [7:0] tt, logic [7:0] hh);
      if (tt >= 8'hc0) fl[BIT_TH] = 1'b1;
      if (tt <= 8'h40) fl[BIT_TL] = 1'b1;
      if (hh >= 8'hc0) fl[BIT_HH] = 1'b1;
      return fl;
   endfunction : exp_flags
   initial begin
      rst_n_i = 1'b0;
      minute_tick = 1'b0;
      sample_tick = 1'b0;
      rtc = '0;
      meas = '0;
      thresh = '{8'hc0, 8'h40, 8'hc0, 8'h40};
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      // device count base: its reset value is not pinned down
      rd_reg(IDX_DCNT, 3, d0);
      expect_reg("alarm", IDX_ALARM, 1, 8'hf0);
      wr(IDX_GSTAT, 8'hff);
      expect_reg("status", IDX_GSTAT, 1, 8'hc0);
      bus(1'b0, 10'h300, 8'h00, f, e);
      chk("slverr", e, 1'b1);
      wr(IDX_DELAY, 8'h02);
      wr(IDX_DELAY + 10'h001, 8'h00);
      wr(IDX_DELAY + 10'h002, 8'h00);
      expect_reg("delay", IDX_DELAY, 3, 24'h00_0002);
      wr(IDX_CTRL, 8'h7b);
      wr(IDX_CMD, 8'h02);
      expect_reg("status", IDX_GSTAT, 1, 8'hc0);
      wr(IDX_CMD, 8'h01);
      expect_reg("alarm", IDX_ALARM, 1, 8'h70);
      expect_reg("status", IDX_GSTAT, 1, 8'hc8);
      expect_reg("dcount", IDX_DCNT, 3, d0);
      wr(IDX_CMD, 8'h02);
      expect_reg("status", IDX_GSTAT, 1, 8'hd2);
      chk("active", active, 1'b1);
      minutes2();
      pulse_meas(1'b0, 8'h80, 8'h80);
      expect_reg("dcount", IDX_DCNT, 3, d0 + 1);
      expect_reg("mcount", IDX_MCNT, 3, 8'h00);
      wr(IDX_CMD, 8'h04);
      expect_reg("status", IDX_GSTAT, 1, 8'hd0);
      wr(IDX_CMD, 8'h01);
      expect_reg("status", IDX_GSTAT, 1, 8'hd8);
      thresh.temp_hi <= 8'h00;
      pulse_meas(1'b1, 8'h80, 8'h80);
      thresh.temp_hi <= 8'hc0;
      expect_reg("status", IDX_GSTAT, 1, 8'hc8);
      expect_reg("alarm", IDX_ALARM, 1, 8'h72);
      expect_reg("dcount", IDX_DCNT, 3, d0 + 2);
      wr(IDX_CMD, 8'h01);
      wr(IDX_CMD, 8'h02);
      // an alarm during the start delay must not be tested
      pulse_meas(1'b0, 8'h10, 8'h80);
      expect_reg("alarm", IDX_ALARM, 1, 8'h70);
      sreq_chk(1'b0);
      wr(IDX_DELAY, 8'h55);
      expect_reg("delay", IDX_DELAY, 3, 24'h00_0002);
      minutes2();
      expect_reg("dcount", IDX_DCNT, 3, d0 + 2);
      stamp = 48'({$random(seed), $random(seed)});
      rtc <= stamp;
      pulse_meas(1'b0, 8'h10, 8'h80);
      expect_reg("status", IDX_GSTAT, 1, 8'hc2);
      expect_reg("alarm", IDX_ALARM, 1, 8'h71);
      expect_reg("mcount", IDX_MCNT, 3, 8'h00);
      f = 8'h71;
      for (int k = 0; k < 12; k++) begin
         t = (k == 0) ? 8'hc0 : 8'($random(seed));
         h = (k == 0) ? 8'hc0 : (k == 1) ? 8'h40 : 8'($random(seed));
         rtc <= 48'($random(seed));
         pulse_meas(1'b0, t, h);
         f = exp_flags(f, t, h);
      end
      expect_reg("alarm", IDX_ALARM, 1, f);
      expect_reg("mcount", IDX_MCNT, 3, 8'h0c);
      expect_reg("dcount", IDX_DCNT, 3, d0 + 15);
      expect_reg("stamp", IDX_STAMP, 6, stamp);
      sreq_chk(1'b1);
      wr(IDX_CMD, 8'h04);
      expect_reg("status", IDX_GSTAT, 1, 8'hc0);
      chk("active", active, 1'b0);
      print_verdict();
   end
endmodule : mission_status_counters_test
